// File: ial_alu.sv
`timescale 1ns/1ps
// Summary of operation
// - Sum adds second value or 12-bit constant to first source, writes result.
// - Sum-with-carry adds first source, second value and carry flag.
// - Difference subtracts second value or 12-bit constant from first source.
// - Difference-with-borrow subtracts, then one less when carry is clear.
// - Reversed difference subtracts first source from second value.
// - Arithmetic with no destination writes back into first source register.
// - Flag-write arithmetic updates N, Z, C and V from the result.
// - Without flag-write option flags stay unchanged for all but the two compares.
// - Program counter operand has its two low bits forced to zero.
// - Sum into program counter branches with bit zero forced to zero.
// - Conjunction, disjunction, exclusive disjunction act bitwise on 32 bits.
// - Masked clear is first source AND NOT second value.
// - Disjunction with inverse is first source OR NOT second value.
// - Flag-write logic updates N, Z, carry from shifter, never V.
// - Register shift amount uses only its low byte, 0 to 255.
// - Immediate shift amount is six bits, 0-63, for every shift; rotate uses only its low five bits.
// - Rotate through carry moves the source right by exactly one.
// - Shifts write only the destination, source register untouched.
// - Flag-write shifts set N, Z, C last out; C kept for zero length.
// - Leading zero count: 32 for zero, 0 when bit 31 set.
// - Leading zero count never modifies any flag.
// - Compare by difference subtracts like flagged difference, result discarded.
// - Both compares update N, Z, C and V whenever the predicate passes, with or without flag-write.
module ial_alu (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             wb_valid,
	output logic      [3:0]  wb_index,
	output logic      [31:0] wb_data,
	output logic             branch_valid,
	output logic      [31:0] branch_addr,
	output logic      [3:0]  flags_out
);

	// Bus state
	logic                  dph_write_ff;
	logic [7:0]            dph_addr_ff;
	logic [31:0]           hrdata_ff;
	// Operand and command registers
	logic [31:0]           first_src_ff;
	logic [31:0]           second_val_ff;
	logic [31:0]           shift_amt_ff;
	ial_pkg::ial_cmd_type  cmd_ff;
	logic                  go_ff;
	// Results
	ial_pkg::ial_flags_type flags_ff;
	logic [31:0]           result_ff;
	logic                  wb_valid_ff;
	logic [3:0]            wb_index_ff;
	logic                  branch_valid_ff;
	logic [31:0]           branch_addr_ff;

	// Address phase decode; hsize is ignored since only words are served
	wire        addr_take  = hsel & htrans[1] & hready;
	wire [7:0]  addr_ofs   = {haddr[7:2], 2'b00};
	wire        wr_dph     = dph_write_ff;
	wire        wr_first   = wr_dph & (dph_addr_ff == ial_pkg::OFS_FIRST_SRC);
	wire        wr_second  = wr_dph & (dph_addr_ff == ial_pkg::OFS_SECOND_VAL);
	wire        wr_amt     = wr_dph & (dph_addr_ff == ial_pkg::OFS_SHIFT_AMT);
	wire        wr_cmd     = wr_dph & (dph_addr_ff == ial_pkg::OFS_COMMAND);
	wire        wr_flags   = wr_dph & (dph_addr_ff == ial_pkg::OFS_FLAGS);
	wire        hi_addr    = (haddr[31:8] != 24'h000000);

	// Status word seen by software
	wire [31:0] status_word = ({28'h0000000, wb_index_ff} << ial_pkg::STAT_POS_WB_IDX)
		| ({31'h00000000, wb_valid_ff} << ial_pkg::STAT_POS_WB_VAL)
		| ({31'h00000000, branch_valid_ff} << ial_pkg::STAT_POS_BRANCH);
	wire [31:0] flags_word  = {flags_ff, 28'h0000000};

	// Read mux; unmapped offsets read zero and still answer OKAY
	logic [31:0] rd_mux;
	always_comb begin
		case (addr_ofs)
			ial_pkg::OFS_FIRST_SRC:  rd_mux = first_src_ff;
			ial_pkg::OFS_SECOND_VAL: rd_mux = second_val_ff;
			ial_pkg::OFS_SHIFT_AMT:  rd_mux = shift_amt_ff;
			ial_pkg::OFS_COMMAND:    rd_mux = cmd_ff;
			ial_pkg::OFS_RESULT:     rd_mux = result_ff;
			ial_pkg::OFS_FLAGS:      rd_mux = flags_word;
			ial_pkg::OFS_STATUS:     rd_mux = status_word;
			default:                 rd_mux = ial_pkg::RST_WORD;
		endcase
	end

	// Bus phase tracking; zero wait states, read data latched at address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_write_ff <= 1'b0;
			dph_addr_ff  <= 8'h00;
			hrdata_ff    <= ial_pkg::RST_WORD;
		end else begin
			dph_write_ff <= addr_take & hwrite & ~hi_addr;
			if (addr_take) begin
				dph_addr_ff <= addr_ofs;
			end
			if (addr_take & ~hwrite) begin
				hrdata_ff <= hi_addr ? ial_pkg::RST_WORD : rd_mux;
			end
		end
	end

	// Operand registers and command launch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			first_src_ff  <= ial_pkg::RST_WORD;
			second_val_ff <= ial_pkg::RST_WORD;
			shift_amt_ff  <= ial_pkg::RST_WORD;
			cmd_ff        <= ial_pkg::RST_WORD;
			go_ff         <= 1'b0;
		end else begin
			if (wr_first)  first_src_ff  <= hwdata;
			if (wr_second) second_val_ff <= hwdata;
			if (wr_amt)    shift_amt_ff  <= hwdata;
			if (wr_cmd)    cmd_ff        <= hwdata;
			go_ff <= wr_cmd;
		end
	end

	// Operation class decode
	wire ial_pkg::ial_op_type op = cmd_ff.op;
	wire is_comp_diff = (op == ial_pkg::OP_COMPARE_BY_DIFFERENCE);
	wire is_comp_sum  = (op == ial_pkg::OP_COMPARE_BY_SUM);
	wire is_compare  = is_comp_diff | is_comp_sum;
	wire is_arith    = (op <= ial_pkg::OP_REVERSED_DIFFERENCE) | is_compare;
	wire is_logic    = (op >= ial_pkg::OP_BITWISE_CONJUNCTION)
		& (op <= ial_pkg::OP_DISJUNCTION_WITH_INVERSE);
	wire is_shift    = (op >= ial_pkg::OP_ARITH_RIGHT_SHIFT)
		& (op <= ial_pkg::OP_ROTATE_THROUGH_CARRY);
	wire is_lz       = (op == ial_pkg::OP_LEADING_ZERO_COUNT);

	// First operand: program counter base is word aligned
	wire [31:0] a_val = cmd_ff.first_src_is_pc ? {first_src_ff[31:2], 2'b00}
		: first_src_ff;
	// Second operand: zero-extended 12-bit constant or flexible value
	wire [31:0] b_val = cmd_ff.use_const
		? {20'h00000, second_val_ff[ial_pkg::CONST_BITS-1:0]} : second_val_ff;

	// Adder operands; subtraction is addition of the inverse
	logic [31:0] add_x;
	logic [31:0] add_y;
	logic        add_cin;
	always_comb begin
		add_x   = a_val;
		add_y   = b_val;
		add_cin = 1'b0;
		case (op)
			ial_pkg::OP_SUM_WITH_CARRY: begin
				add_cin = flags_ff.c;
			end
			ial_pkg::OP_DIFFERENCE, ial_pkg::OP_COMPARE_BY_DIFFERENCE: begin
				add_y   = ~b_val;
				add_cin = 1'b1;
			end
			ial_pkg::OP_DIFFERENCE_WITH_BORROW: begin
				add_y   = ~b_val;
				add_cin = flags_ff.c;
			end
			ial_pkg::OP_REVERSED_DIFFERENCE: begin
				add_x   = b_val;
				add_y   = ~a_val;
				add_cin = 1'b1;
			end
			default: begin
				add_cin = 1'b0;
			end
		endcase
	end

	// One 33-bit addition; carry out is the no-borrow flag for differences
	wire [32:0] add_sum = {1'b0, add_x} + {1'b0, add_y} + {32'h00000000, add_cin};
	wire        add_c   = add_sum[32];
	wire        add_v   = (add_x[31] == add_y[31]) & (add_sum[31] != add_x[31]);

	// Bitwise logic over all 32 bits
	logic [31:0] logic_res;
	always_comb begin
		case (op)
			ial_pkg::OP_BITWISE_CONJUNCTION:           logic_res = a_val & b_val;
			ial_pkg::OP_BITWISE_DISJUNCTION:           logic_res = a_val | b_val;
			ial_pkg::OP_BITWISE_EXCLUSIVE_DISJUNCTION: logic_res = a_val ^ b_val;
			ial_pkg::OP_MASKED_CLEAR:                  logic_res = a_val & ~b_val;
			ial_pkg::OP_DISJUNCTION_WITH_INVERSE:      logic_res = a_val | ~b_val;
			default:                                   logic_res = a_val & b_val;
		endcase
	end

	// Shift amount: low byte of the amount register, or the immediate
	wire [7:0]  shamt    = cmd_ff.amt_from_reg ? shift_amt_ff[7:0]
		: {2'b00, cmd_ff.shift_imm};
	wire        shamt_nz = (shamt != 8'h00);
	wire [31:0] src      = second_val_ff;

	// Wide shifters make amounts of 32 and above fall out naturally
	wire [63:0] shl_wide = {32'h00000000, src} << shamt;
	wire [63:0] shr_wide = {src, 32'h00000000} >> shamt;
	wire [63:0] sar_wide = 64'($signed({src, 32'h00000000}) >>> shamt);
	wire [63:0] rot_wide = {src, src} >> shamt[4:0];

	logic [31:0] shift_res;
	logic        shift_c;
	always_comb begin
		shift_res = src;
		shift_c   = flags_ff.c;
		case (op)
			ial_pkg::OP_LOGICAL_LEFT_SHIFT: begin
				shift_res = shl_wide[31:0];
				shift_c   = shamt_nz ? shl_wide[32] : flags_ff.c;
			end
			ial_pkg::OP_LOGICAL_RIGHT_SHIFT: begin
				shift_res = shr_wide[63:32];
				shift_c   = shamt_nz ? shr_wide[31] : flags_ff.c;
			end
			ial_pkg::OP_ARITH_RIGHT_SHIFT: begin
				shift_res = sar_wide[63:32];
				shift_c   = shamt_nz ? sar_wide[31] : flags_ff.c;
			end
			ial_pkg::OP_ROTATE_RIGHT: begin
				shift_res = rot_wide[31:0];
				shift_c   = shamt_nz ? rot_wide[31] : flags_ff.c;
			end
			ial_pkg::OP_ROTATE_THROUGH_CARRY: begin
				shift_res = {flags_ff.c, src[31:1]};
				shift_c   = src[0];
			end
			default: begin
				shift_res = src;
				shift_c   = flags_ff.c;
			end
		endcase
	end

	// Leading zeros; later (higher) set bits override earlier ones
	logic [5:0] lz_cnt;
	always_comb begin
		lz_cnt = ial_pkg::LZ_ALL_ZERO;
		for (int i = 0; i < 32; i++) begin
			if (src[i]) lz_cnt = 6'(31 - i);
		end
	end

	// Result selection
	wire [31:0] exec_res = is_arith ? add_sum[31:0]
		: is_logic ? logic_res
		: is_shift ? shift_res
		: {26'h0000000, lz_cnt};

	// Flag update choice per class
	ial_pkg::ial_flags_type nxt_flags;
	always_comb begin
		nxt_flags.n = exec_res[31];
		nxt_flags.z = (exec_res == 32'h00000000);
		nxt_flags.c = flags_ff.c;
		nxt_flags.v = flags_ff.v;
		if (is_arith) begin
			nxt_flags.c = add_c;
			nxt_flags.v = add_v;
		end else if (is_logic) begin
			if (cmd_ff.op2_carry_valid) nxt_flags.c = cmd_ff.op2_carry;
		end else if (is_shift) begin
			nxt_flags.c = shift_c;
		end
	end

	// Which writes happen; the predicate gates everything
	wire flag_upd  = go_ff & cmd_ff.pred_pass & ~is_lz
		& (cmd_ff.set_flags | is_compare);
	wire dest_wr   = go_ff & cmd_ff.pred_pass & ~is_compare;
	wire arith_def = is_arith & ~cmd_ff.dest_present;
	wire [3:0] nxt_wb_index = arith_def ? cmd_ff.first_src_idx
		: cmd_ff.dest_idx;
	wire take_branch = dest_wr & cmd_ff.dest_is_pc & (op == ial_pkg::OP_SUM);

	// Flags; a hardware update in the same cycle beats a software write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_ff <= ial_pkg::RST_FLAGS;
		end else if (flag_upd) begin
			flags_ff <= nxt_flags;
		end else if (wr_flags) begin
			flags_ff <= hwdata[ial_pkg::FLAG_POS_N:ial_pkg::FLAG_POS_V];
		end
	end

	// Writeback and branch outputs, registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			result_ff       <= ial_pkg::RST_WORD;
			wb_valid_ff     <= 1'b0;
			wb_index_ff     <= 4'h0;
			branch_valid_ff <= 1'b0;
			branch_addr_ff  <= ial_pkg::RST_WORD;
		end else begin
			wb_valid_ff     <= dest_wr;
			branch_valid_ff <= take_branch;
			if (dest_wr) begin
				result_ff   <= exec_res;
				wb_index_ff <= nxt_wb_index;
			end
			if (take_branch) begin
				branch_addr_ff <= {add_sum[31:1], 1'b0};
			end
		end
	end

	// Port drive; zero wait states and always OKAY keep the slave simple
	assign hrdata       = hrdata_ff;
	assign hreadyout    = 1'b1;
	assign hresp        = 1'b0;
	assign wb_valid     = wb_valid_ff;
	assign wb_index     = wb_index_ff;
	assign wb_data      = result_ff;
	assign branch_valid = branch_valid_ff;
	assign branch_addr  = branch_addr_ff;
	assign flags_out    = flags_ff;

	// Helper signals seen only by the checks
	wire [3:0] chk_first_idx = cmd_ff.first_src_idx;
	wire       chk_sub_flag  = go_ff & cmd_ff.pred_pass & cmd_ff.set_flags
		& (op == ial_pkg::OP_DIFFERENCE);
	wire       chk_no_borrow = (a_val >= b_val);
	wire       chk_pc_sum    = go_ff & cmd_ff.pred_pass & cmd_ff.first_src_is_pc
		& cmd_ff.use_const & (op == ial_pkg::OP_SUM);
	wire [1:0] chk_b_low     = b_val[1:0];
	wire       chk_lz        = go_ff & cmd_ff.pred_pass & is_lz;
	wire       chk_top_set   = src[31];
	wire       chk_src_zero  = (src == 32'h00000000);

	sequence s_go_fail;
		go_ff & ~cmd_ff.pred_pass;
	endsequence

	sequence s_go_quiet;
		go_ff & cmd_ff.pred_pass & ~cmd_ff.set_flags & ~is_compare;
	endsequence

	property p_pred_fail;
		@(posedge hclk) disable iff (!hresetn)
		s_go_fail |=> !wb_valid && !branch_valid;
	endproperty
	a_pred_fail: assert property (p_pred_fail) else $error("write after failed predicate");

	property p_no_s_hold;
		@(posedge hclk) disable iff (!hresetn)
		s_go_quiet |=> (flags_out == $past(flags_out)) || $past(wr_flags);
	endproperty
	a_no_s_hold: assert property (p_no_s_hold) else $error("flags moved without flag write");

	property p_lz_flags;
		@(posedge hclk) disable iff (!hresetn)
		go_ff && is_lz && !wr_flags |=> $stable(flags_out);
	endproperty
	a_lz_flags: assert property (p_lz_flags) else $error("zero count changed flags");

	property p_comp_discard;
		@(posedge hclk) disable iff (!hresetn)
		go_ff && is_compare |=> !wb_valid;
	endproperty
	a_comp_discard: assert property (p_comp_discard) else $error("compare wrote a result");

	property p_default_dest;
		@(posedge hclk) disable iff (!hresetn)
		dest_wr && arith_def |=> wb_valid && (wb_index == $past(chk_first_idx));
	endproperty
	a_default_dest: assert property (p_default_dest) else $error("wrong default destination");

	property p_sub_carry;
		@(posedge hclk) disable iff (!hresetn)
		chk_sub_flag |=> flags_out[1] == $past(chk_no_borrow);
	endproperty
	a_sub_carry: assert property (p_sub_carry) else $error("difference carry wrong");

	property p_pc_align;
		@(posedge hclk) disable iff (!hresetn)
		chk_pc_sum |=> wb_data[1:0] == $past(chk_b_low);
	endproperty
	a_pc_align: assert property (p_pc_align) else $error("pc base not word aligned");

	property p_branch_even;
		@(posedge hclk) disable iff (!hresetn)
		take_branch |=> branch_valid && !branch_addr[0] ##1 !branch_valid || $past(take_branch);
	endproperty
	a_branch_even: assert property (p_branch_even) else $error("branch target odd");

	property p_lz_ends;
		@(posedge hclk) disable iff (!hresetn)
		chk_lz |=> (wb_data == 32'h00000000) == $past(chk_top_set)
			&& (wb_data == 32'h00000020) == $past(chk_src_zero);
	endproperty
	a_lz_ends: assert property (p_lz_ends) else $error("zero count end value wrong");

endmodule : ial_alu

// File: ial_pkg.sv
package ial_pkg;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] OFS_FIRST_SRC   = 8'h00;
	localparam logic [7:0] OFS_SECOND_VAL  = 8'h04;
	localparam logic [7:0] OFS_SHIFT_AMT   = 8'h08;
	localparam logic [7:0] OFS_COMMAND     = 8'h0C;
	localparam logic [7:0] OFS_RESULT      = 8'h10;
	localparam logic [7:0] OFS_FLAGS       = 8'h14;
	localparam logic [7:0] OFS_STATUS      = 8'h18;

	// Field positions in the flag register
	localparam int FLAG_POS_V = 28;
	localparam int FLAG_POS_C = 29;
	localparam int FLAG_POS_Z = 30;
	localparam int FLAG_POS_N = 31;

	// Field positions in the status register
	localparam int STAT_POS_WB_IDX  = 0;
	localparam int STAT_POS_WB_VAL  = 4;
	localparam int STAT_POS_BRANCH  = 5;

	// Values after reset
	localparam logic [31:0] RST_WORD    = 32'h0000_0000;
	localparam logic [3:0]  RST_FLAGS   = 4'h0;

	// Widths and limits
	localparam int          CONST_BITS  = 12;
	localparam logic [5:0]  LZ_ALL_ZERO  = 6'h20;
	localparam logic [7:0]  WORD_BITS   = 8'h20;

	// Operation codes
	typedef enum logic [4:0] {
		OP_SUM                   = 5'h00,
		OP_SUM_WITH_CARRY        = 5'h01,
		OP_DIFFERENCE            = 5'h02,
		OP_DIFFERENCE_WITH_BORROW = 5'h03,
		OP_REVERSED_DIFFERENCE   = 5'h04,
		OP_BITWISE_CONJUNCTION   = 5'h05,
		OP_BITWISE_DISJUNCTION   = 5'h06,
		OP_BITWISE_EXCLUSIVE_DISJUNCTION = 5'h07,
		OP_MASKED_CLEAR          = 5'h08,
		OP_DISJUNCTION_WITH_INVERSE = 5'h09,
		OP_ARITH_RIGHT_SHIFT     = 5'h0A,
		OP_LOGICAL_LEFT_SHIFT    = 5'h0B,
		OP_LOGICAL_RIGHT_SHIFT   = 5'h0C,
		OP_ROTATE_RIGHT          = 5'h0D,
		OP_ROTATE_THROUGH_CARRY  = 5'h0E,
		OP_LEADING_ZERO_COUNT    = 5'h0F,
		OP_COMPARE_BY_DIFFERENCE = 5'h10,
		OP_COMPARE_BY_SUM        = 5'h11
	} ial_op_type;

	// Command word, packed as written to the command register
	typedef struct packed {
		logic [3:0]  spare;
		logic        op2_carry;
		logic        op2_carry_valid;
		logic [5:0]  shift_imm;
		logic [3:0]  first_src_idx;
		logic [3:0]  dest_idx;
		logic        pred_pass;
		logic        dest_present;
		logic        dest_is_pc;
		logic        first_src_is_pc;
		logic        amt_from_reg;
		logic        use_const;
		logic        set_flags;
		ial_op_type  op;
	} ial_cmd_type;

	// Condition flags
	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} ial_flags_type;

endpackage : ial_pkg

// File: ial_rf_model.sv
`timescale 1ns/1ps
// Far-side stand-in for the register file and fetch stage: counts writebacks, tracks the PC
module ial_rf_model (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        wb_valid,
	input  wire logic        branch_valid,
	input  wire logic [31:0] branch_addr,
	output logic      [31:0] wr_cnt_ff,
	output logic      [31:0] pc_ff
);
	// A lost or doubled pulse shows up as a count mismatch at the end of the run
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_cnt_ff <= 32'h0;
			pc_ff     <= 32'h0;
		end else begin
			if (wb_valid) begin
				wr_cnt_ff <= wr_cnt_ff + 32'h1;
			end
			if (branch_valid) begin
				pc_ff <= branch_addr;
			end
		end
	end
endmodule : ial_rf_model

// File: tb_top.sv
`timescale 1ns/1ps
`define CHK(gv, ev) begin \
	compares++; \
	if ((gv) !== (ev)) begin \
		miscompares++; \
		$display("ERROR at %0t ns: got %0h, expected %0h", $time, (gv), (ev)); \
	end \
end
module tb_top;
	localparam logic [31:0] A_SRC = {24'h00, ial_pkg::OFS_FIRST_SRC};
	localparam logic [31:0] A_B   = {24'h00, ial_pkg::OFS_SECOND_VAL};
	localparam logic [31:0] A_S   = {24'h00, ial_pkg::OFS_SHIFT_AMT};
	localparam logic [31:0] A_CMD = {24'h00, ial_pkg::OFS_COMMAND};
	localparam logic [31:0] A_RES = {24'h00, ial_pkg::OFS_RESULT};
	localparam logic [31:0] A_FLG = {24'h00, ial_pkg::OFS_FLAGS};
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, wb_valid, branch_valid;
	logic [31:0] haddr, hwdata, hrdata, wb_data, branch_addr, wr_cnt, pc, rd, bv;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  wb_index, flags_out, fl, f;
	logic [36:0] e;
	logic [36:0] wq[$];
	logic [31:0] bq[$];
	ial_pkg::ial_cmd_type c;
	int compares, miscompares, nwb;
	// Command, first source, second value, shift amount
	logic [127:0] tbl [20] = '{
		128'h00013C60_FFFFFFFF_ABCDEFFF_00000000, 128'h00013C22_00000005_00000006_00000000,
		128'h00013C23_00000010_00000010_00000000, 128'h00013C24_80000000_00000000_00000000,
		128'h00013820_00000001_00000002_00000000, 128'h00013D22_00001003_00000004_00000000,
		128'h0001FF40_00002002_00000101_00000000, 128'h00013CAB_00000000_00000003_00000120,
		128'h02013C2A_00000000_80000001_00000000, 128'h02013C2C_00000000_40000000_00000000,
		128'h01F13C2D_00000000_00000001_00000000, 128'h00013C2B_00000000_80000000_00000000,
		128'h00013C2E_00000000_00000003_00000000, 128'h00013C2F_00000000_00000000_00000000,
		128'h00013C2F_00000000_80000000_00000000, 128'h00013C30_00000007_00000007_00000000,
		128'h00013C31_FFFFFFFF_00000001_00000000, 128'h00013420_00000001_00000001_00000000,
		128'h0C013C28_000000FF_0000000F_00000000, 128'h00013C29_00000000_FFFFFFF0_00000000};

	ial_alu dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
		.hrdata, .hreadyout, .hresp, .wb_valid, .wb_index, .wb_data, .branch_valid,
		.branch_addr, .flags_out);
	ial_rf_model rf_u (.hclk, .hresetn, .wb_valid, .branch_valid, .branch_addr,
		.wr_cnt_ff(wr_cnt), .pc_ff(pc));
	assign hready = hreadyout;

	always #12.5 hclk = ~hclk;

	// One single AHB-Lite transfer; read data is taken at the end of the data phase
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		`CHK(hresp, 1'b0)
	endtask : bus

	// Reference behaviour; updates the expected flags and queues the expected writeback
	task automatic model(input ial_pkg::ial_cmd_type k, input logic [31:0] a,
		input logic [31:0] b, input logic [31:0] s);
		logic [31:0] x, y, p, q, r;
		logic [32:0] t;
		logic [63:0] w;
		logic ci, cy, ov, ar;
		logic [7:0] n;
		logic [3:0] idx;
		x = k.first_src_is_pc ? {a[31:2], 2'b00} : a;
		y = k.use_const ? {20'h0, b[11:0]} : b;
		n = k.amt_from_reg ? s[7:0] : {2'b00, k.shift_imm};
		{cy, ov, ar, p, q, ci, r} = {fl[1], fl[0], 1'b1, x, y, 1'b0, 32'h0};
		case (k.op)
			5'h01: ci = fl[1];
			5'h02, 5'h10: {q, ci} = {~y, 1'b1};
			5'h03: {q, ci} = {~y, fl[1]};
			5'h04: {p, q, ci} = {y, ~x, 1'b1};
			5'h00, 5'h11: ar = 1'b1;
			default: ar = 1'b0;
		endcase
		t = {1'b0, p} + {1'b0, q} + {32'h0, ci};
		if (ar) begin
			r = t[31:0];
			cy = t[32];
			ov = (p[31] == q[31]) && (r[31] != p[31]);
		end
		case (k.op)
			5'h05: r = x & y;
			5'h06: r = x | y;
			5'h07: r = x ^ y;
			5'h08: r = x & ~y;
			5'h09: r = x | ~y;
			5'h0A: begin w = $signed({b, 32'h0}) >>> n; {r, cy} = w[63:31]; end
			5'h0B: begin w = {32'h0, b} << n; {cy, r} = w[32:0]; end
			5'h0C: begin w = {b, 32'h0} >> n; {r, cy} = w[63:31]; end
			5'h0D: begin w = {b, b} >> n[4:0]; r = w[31:0]; cy = r[31]; end
			5'h0E: begin r = {fl[1], b[31:1]}; cy = b[0]; end
			5'h0F: begin r = 32'h20; for (int i = 0; i < 32; i++) if (b[i]) r = 32'(31 - i); end
			default: ;
		endcase
		// A zero-length shift passes the value through and keeps carry
		if (k.op inside {[5'h0A:5'h0D]} && n == 8'h00) {r, cy} = {b, fl[1]};
		if (k.op inside {[5'h05:5'h09]} && k.op2_carry_valid) cy = k.op2_carry;
		if (k.pred_pass && k.op != 5'h0F && (k.set_flags || k.op >= 5'h10)) begin
			fl = {r[31], r == 32'h0, cy, ov};
		end
		if (k.pred_pass && k.op < 5'h10) begin
			idx = (k.op <= 5'h04 && !k.dest_present) ? k.first_src_idx : k.dest_idx;
			if (k.dest_is_pc && k.op == 5'h00) bq.push_back({r[31:1], 1'b0});
			wq.push_back({!(k.dest_is_pc && k.op == 5'h00), idx, r});
			nwb++;
		end
	endtask : model

	// Load operands, launch the command, then compare the flags once it has landed
	task automatic run(input logic [127:0] v);
		bus(1'b1, A_SRC, v[95:64]);
		bus(1'b1, A_B, v[63:32]);
		bus(1'b1, A_S, v[31:0]);
		model(v[127:96], v[95:64], v[63:32], v[31:0]);
		bus(1'b1, A_CMD, v[127:96]);
		repeat (3) @(posedge hclk);
		`CHK(flags_out, fl)
	endtask : run

	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done

	// Each writeback or branch pulse consumes the oldest expectation
	always @(posedge hclk) begin
		if (wb_valid === 1'b1) begin
			`CHK(wq.size() > 0, 1'b1)
			e = (wq.size() > 0) ? wq.pop_front() : 37'h0;
			`CHK(wb_index, e[35:32])
			if (e[36]) `CHK(wb_data, e[31:0])
		end
		if (branch_valid === 1'b1) begin
			`CHK(bq.size() > 0, 1'b1)
			bv = (bq.size() > 0) ? bq.pop_front() : 32'h1;
			`CHK(branch_addr, bv)
		end
	end

	// Watchdog sized well above the roughly 1000 cycles the tests need
	initial begin
		repeat (8000) @(posedge hclk);
		miscompares++;
		test_done();
	end

	initial begin
		{hclk, hresetn, hsel, hwrite, haddr, htrans, hwdata, fl} = '0;
		hsize = 3'h2;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		void'($urandom(31));
		// Reset values, read-only and unmapped places, read-write registers
		bus(1'b0, A_FLG, 32'h0);
		`CHK(rd[31:28], ial_pkg::RST_FLAGS)
		bus(1'b1, A_SRC, 32'h0000_0055);
		bus(1'b1, A_RES, 32'hFFFF_FFFF);
		bus(1'b0, A_RES, 32'h0);
		`CHK(rd, ial_pkg::RST_WORD)
		bus(1'b0, 32'h0000_0100, 32'h0);
		`CHK(rd, 32'h0)
		bus(1'b1, A_FLG, 32'hA000_0000);
		fl = 4'hA;
		bus(1'b0, A_FLG, 32'h0);
		`CHK(rd[31:28], fl)
		$display("register access test done");
		foreach (tbl[i]) run(tbl[i]);
		$display("directed operation test done");
		// Random operands and commands over every operation code
		for (int i = 0; i < 60; i++) begin
			c = $urandom;
			c.op = ial_pkg::ial_op_type'(5'($urandom_range(17, 0)));
			{c.spare, c.dest_is_pc, c.first_src_is_pc} = '0;
			c.use_const = c.use_const & (c.op == 5'h00 || c.op == 5'h02);
			f = 4'($urandom);
			bus(1'b1, A_FLG, {f, 28'h0});
			fl = f;
			run({c, $urandom, $urandom, $urandom});
		end
		repeat (4) @(posedge hclk);
		`CHK(wr_cnt, 32'(nwb))
		`CHK(pc, 32'h0000_2100)
		$display("random operation test done");
		test_done();
	end
endmodule : tb_top
